// [core/dscg_access_guard.sv]
// bus guard that faults accesses to a unit whose clock is off
`timescale 1ns/1ns
module dscg_access_guard (
  input wire logic clk,
  input wire logic srst,
  input wire logic clock_on,
  input wire logic req_psel,
  input wire logic req_penable,
  input wire logic unit_pready,
  input wire logic unit_pslverr,
  output logic unit_psel,
  output logic rsp_pready,
  output logic rsp_pslverr,
  output logic fault
);

  logic blocked;
  logic next_blocked;

  // decision taken in the setup cycle and held through the access phase
  always_comb begin
    next_blocked = blocked;
    if (req_psel && !req_penable) begin
      next_blocked = !clock_on;
    end else if (!req_psel) begin
      next_blocked = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      blocked <= 1'b0;
    end else begin
      blocked <= next_blocked;
    end
  end

  wire logic setup_block = req_psel && !req_penable && !clock_on;
  wire logic is_blocked = req_penable ? blocked : setup_block;

  assign unit_psel = req_psel && !is_blocked;
  assign rsp_pready = is_blocked ? 1'b1 : unit_pready;
  assign rsp_pslverr = is_blocked ? 1'b1 : unit_pslverr;
  assign fault = req_psel && req_penable && blocked;

endmodule

// [core/dscg_clock_gate.sv]
// glitch-free clock gate for one unit
`timescale 1ns/1ns
module dscg_clock_gate (
  input wire logic clk,
  input wire logic srst,
  input wire logic enable,
  output logic gated_clk
);

  logic en_low;
  logic next_en_low;

  always_comb begin
    next_en_low = srst ? 1'b0 : enable;
  end

  // enable changes only while clk is low, so no runt pulse
  always_ff @(negedge clk) begin
    en_low <= next_en_low;
  end

  assign gated_clk = clk & en_low;

endmodule

// [core/dscg_gate_bank.sv]
// deep-sleep clock gate bank: gating registers, power state, guards, interrupt
// Summary of operation
// - a unit is clocked while its selected gating bit is set and receives no clock while it is clear
// - any access to a unit whose clock is off is answered with a bus fault and not passed on
// - the deep-sleep gating register is a read/write register at offset 0x120
// - the deep-sleep gating register resets to 0x00000040
// - every gating bit resets to zero so all gated units start unclocked
// - bit 20 enables the clock of the pulse-width modulator
// - bit 16 enables the clock of converter zero
// - bit 3 enables the clock of the watchdog
// - all other bits are reserved, read-only, read as their reset value and ignore writes
// - run, sleep and deep-sleep gating registers exist and the one of the current power state gates
// - sleep and deep-sleep registers act only while automatic clock gating is set
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`include "dscg_regs.svh"
module dscg_gate_bank
  import dscg_pkg::*;
#(
  parameter int ADDR_WIDTH = 12,
  parameter int UNITS = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_active,
  input wire logic deep_sleep_active,
  input wire logic [UNITS-1:0] unit_req_psel,
  input wire logic unit_req_penable,
  input wire logic [UNITS-1:0] unit_pready,
  input wire logic [UNITS-1:0] unit_pslverr,
  output logic [UNITS-1:0] unit_psel,
  output logic [UNITS-1:0] unit_rsp_pready,
  output logic [UNITS-1:0] unit_rsp_pslverr,
  output logic [UNITS-1:0] unit_clk,
  output logic [UNITS-1:0] unit_clk_on,
  output logic [1:0] power_state,
  output logic irq
);

  // elaboration checks on the parameters
  if (UNITS != 3) begin : g_bad_units
    $error("gate bank serves exactly three units");
  end
  if (ADDR_WIDTH < 9) begin : g_bad_addr
    $error("address too narrow for the register map");
  end

  // gather the three unit bits of a gating word
  function automatic dscg_units_t unit_bits(input dscg_word_t w);
    unit_bits = {w[`DSCG_PWM_BIT], w[`DSCG_ADC_BIT], w[`DSCG_WATCHDOG_BIT]};
  endfunction

  // byte-lane merge of a write, limited to writable bits
  function automatic dscg_word_t merge(input dscg_word_t old, input dscg_word_t wd,
                                       input logic [3:0] strb, input dscg_word_t mask);
    dscg_word_t lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old & ~lanes) | (wd & lanes);
  endfunction

  // place three unit bits at their gating positions
  function automatic dscg_word_t spread(input dscg_units_t u);
    dscg_word_t w;
    w = 32'h00000000;
    w[`DSCG_PWM_BIT] = u[2];
    w[`DSCG_ADC_BIT] = u[1];
    w[`DSCG_WATCHDOG_BIT] = u[0];
    spread = w;
  endfunction

  // deep sleep wins over sleep; neither means run
  function automatic dscg_power_t pick_state(input logic slp, input logic deep);
    if (deep) begin
      pick_state = DSCG_DEEP;
    end else if (slp) begin
      pick_state = DSCG_SLEEP;
    end else begin
      pick_state = DSCG_RUN;
    end
  endfunction

  localparam logic [11:0] ADDR_MASK = 12'hffc;

  // ---------------- bus decode ----------------
  logic [11:0] word_addr;
  logic setup_phase;
  logic wr_access;
  logic hit_run;
  logic hit_sleep;
  logic hit_deep;
  logic hit_cfg;
  logic hit_status;
  logic hit_enable;
  logic hit_clear;
  logic hit_info;
  logic mapped;

  always_comb begin
    word_addr = 12'(paddr) & ADDR_MASK;
    setup_phase = psel && !penable;
    wr_access = psel && penable && pwrite;
    hit_run = word_addr == `DSCG_RUN_GATE_OFFSET;
    hit_sleep = word_addr == `DSCG_SLEEP_GATE_OFFSET;
    hit_deep = word_addr == `DSCG_DEEP_GATE_OFFSET;
    hit_cfg = word_addr == `DSCG_RUN_CFG_OFFSET;
    hit_status = word_addr == `DSCG_IRQ_STATUS_OFFSET;
    hit_enable = word_addr == `DSCG_IRQ_ENABLE_OFFSET;
    hit_clear = word_addr == `DSCG_IRQ_CLEAR_OFFSET;
    hit_info = word_addr == `DSCG_FAULT_INFO_OFFSET;
    mapped = hit_run || hit_sleep || hit_deep || hit_cfg || hit_status || hit_enable || hit_clear || hit_info;
  end

  // ---------------- gating registers ----------------
  dscg_word_t run_clock_gate_0;
  dscg_word_t sleep_clock_gate_0;
  dscg_word_t deep_sleep_clock_gate_0;
  dscg_word_t run_clock_config;
  dscg_word_t next_run_clock_gate_0;
  dscg_word_t next_sleep_clock_gate_0;
  dscg_word_t next_deep_sleep_clock_gate_0;
  dscg_word_t next_run_clock_config;
  logic auto_clock_gating;

  always_comb begin
    next_run_clock_gate_0 = run_clock_gate_0;
    next_sleep_clock_gate_0 = sleep_clock_gate_0;
    next_deep_sleep_clock_gate_0 = deep_sleep_clock_gate_0;
    next_run_clock_config = run_clock_config;
    if (wr_access && hit_run) begin
      next_run_clock_gate_0 = merge(run_clock_gate_0, pwdata, pstrb, `DSCG_GATE_WRITE_MASK);
    end
    if (wr_access && hit_sleep) begin
      next_sleep_clock_gate_0 = merge(sleep_clock_gate_0, pwdata, pstrb, `DSCG_GATE_WRITE_MASK);
    end
    // only bits 20, 16 and 3 take writes; reserved bits hold their value
    if (wr_access && hit_deep) begin
      next_deep_sleep_clock_gate_0 = merge(deep_sleep_clock_gate_0, pwdata, pstrb,
                                           `DSCG_GATE_WRITE_MASK);
    end
    if (wr_access && hit_cfg) begin
      next_run_clock_config = merge(run_clock_config, pwdata, pstrb, 32'h00000001 << `DSCG_AUTO_GATE_BIT);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      run_clock_gate_0 <= `DSCG_GATE_RESET;
      sleep_clock_gate_0 <= `DSCG_GATE_RESET;
      deep_sleep_clock_gate_0 <= `DSCG_GATE_RESET;
      run_clock_config <= `DSCG_CFG_RESET;
    end else begin
      run_clock_gate_0 <= next_run_clock_gate_0;
      sleep_clock_gate_0 <= next_sleep_clock_gate_0;
      deep_sleep_clock_gate_0 <= next_deep_sleep_clock_gate_0;
      run_clock_config <= next_run_clock_config;
    end
  end

  assign auto_clock_gating = run_clock_config[`DSCG_AUTO_GATE_BIT];

  // ---------------- power state ----------------
  dscg_power_t state;
  dscg_power_t next_state;

  // state follows the power-state levels one cycle late
  always_comb begin
    case (state)
      DSCG_RUN: begin
        next_state = pick_state(sleep_active, deep_sleep_active);
      end
      DSCG_SLEEP: begin
        next_state = pick_state(sleep_active, deep_sleep_active);
      end
      DSCG_DEEP: begin
        next_state = pick_state(sleep_active, deep_sleep_active);
      end
      default: begin
        next_state = DSCG_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= DSCG_RUN;
    end else begin
      state <= next_state;
    end
  end

  assign power_state = state;

  // ---------------- clock enables ----------------
  dscg_units_t clk_on;
  dscg_units_t next_clk_on;

  always_comb begin
    next_clk_on = unit_bits(run_clock_gate_0);
    if (auto_clock_gating) begin
      case (state)
        DSCG_SLEEP: begin
          next_clk_on = unit_bits(sleep_clock_gate_0);
        end
        DSCG_DEEP: begin
          next_clk_on = unit_bits(deep_sleep_clock_gate_0);
        end
        default: begin
          next_clk_on = unit_bits(run_clock_gate_0);
        end
      endcase
    end
  end

  // enables change only on a clock edge
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_on <= 3'h0;
    end else begin
      clk_on <= next_clk_on;
    end
  end

  assign unit_clk_on = clk_on;

  dscg_units_t fault;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_unit
      dscg_clock_gate u_gate (
        .clk(clk),
        .srst(srst),
        .enable(clk_on[g]),
        .gated_clk(unit_clk[g])
      );

      dscg_access_guard u_guard (
        .clk(clk),
        .srst(srst),
        .clock_on(clk_on[g]),
        .req_psel(unit_req_psel[g]),
        .req_penable(unit_req_penable),
        .unit_pready(unit_pready[g]),
        .unit_pslverr(unit_pslverr[g]),
        .unit_psel(unit_psel[g]),
        .rsp_pready(unit_rsp_pready[g]),
        .rsp_pslverr(unit_rsp_pslverr[g]),
        .fault(fault[g])
      );
    end
  endgenerate

  // ---------------- fault interrupt ----------------
  dscg_units_t irq_status;
  dscg_units_t irq_enable;
  dscg_units_t next_irq_status;
  dscg_units_t next_irq_enable;
  dscg_units_t fault_info;
  dscg_units_t next_fault_info;
  dscg_units_t clear_bits;

  always_comb begin
    clear_bits = 3'h0;
    // write-one-to-clear needs both lanes that hold fault bits
    if (wr_access && hit_clear && pstrb[0] && pstrb[2]) begin
      clear_bits = unit_bits(pwdata);
    end
    // a fault in the clearing cycle stays set
    next_irq_status = (irq_status & ~clear_bits) | fault;
    next_irq_enable = irq_enable;
    if (wr_access && hit_enable) begin
      next_irq_enable = unit_bits(merge(spread(irq_enable), pwdata, pstrb, `DSCG_GATE_WRITE_MASK));
    end
    next_fault_info = (fault != 3'h0) ? fault : fault_info;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_status <= `DSCG_IRQ_RESET;
      irq_enable <= `DSCG_IRQ_RESET;
      fault_info <= `DSCG_IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      fault_info <= next_fault_info;
    end
  end

  // level interrupt while an enabled fault bit is set
  assign irq = |(irq_status & irq_enable);

  // ---------------- read path ----------------
  dscg_word_t rd_value;
  dscg_word_t next_prdata;
  logic next_pslverr;

  always_comb begin
    rd_value = 32'h00000000;
    if (hit_run) begin
      rd_value = run_clock_gate_0;
    end else if (hit_sleep) begin
      rd_value = sleep_clock_gate_0;
    end else if (hit_deep) begin
      rd_value = deep_sleep_clock_gate_0;
    end else if (hit_cfg) begin
      rd_value = run_clock_config;
      rd_value[`DSCG_STATE_LSB +: 2] = state;
    end else if (hit_status) begin
      rd_value = spread(irq_status);
    end else if (hit_enable) begin
      rd_value = spread(irq_enable);
    end else if (hit_info) begin
      rd_value = spread(fault_info);
    end
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (setup_phase) begin
      next_prdata = pwrite ? 32'h00000000 : rd_value;
      next_pslverr = !mapped;
    end
  end

  // read data and error are caught in the setup cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // zero wait state: every access is one setup and one access cycle
  assign pready = 1'b1;

endmodule

// [core/dscg_pkg.sv]
// types shared by the clock gate bank
package dscg_pkg;

  typedef logic [31:0] dscg_word_t;

  // gray coded along run, sleep, deep sleep
  typedef enum logic [1:0] {
    DSCG_RUN = 2'h0,
    DSCG_SLEEP = 2'h1,
    DSCG_DEEP = 2'h3
  } dscg_power_t;

  // unit order in every per-unit vector: 0 watchdog, 1 converter, 2 pwm
  typedef logic [2:0] dscg_units_t;

endpackage

// [core/dscg_regs.svh]
// register offsets, field positions, reset values of the clock gate bank
`ifndef DSCG_REGS_SVH
`define DSCG_REGS_SVH

`define DSCG_RUN_GATE_OFFSET 12'h100
`define DSCG_SLEEP_GATE_OFFSET 12'h110
`define DSCG_DEEP_GATE_OFFSET 12'h120
`define DSCG_RUN_CFG_OFFSET 12'h130
`define DSCG_IRQ_STATUS_OFFSET 12'h140
`define DSCG_IRQ_ENABLE_OFFSET 12'h144
`define DSCG_IRQ_CLEAR_OFFSET 12'h148
`define DSCG_FAULT_INFO_OFFSET 12'h14c

`define DSCG_PWM_BIT 20
`define DSCG_ADC_BIT 16
`define DSCG_WATCHDOG_BIT 3
`define DSCG_FIXED_ONE_BIT 6

`define DSCG_GATE_RESET 32'h00000040
`define DSCG_GATE_WRITE_MASK 32'h00110008

`define DSCG_AUTO_GATE_BIT 0
`define DSCG_STATE_LSB 4
`define DSCG_CFG_RESET 32'h00000000
`define DSCG_IRQ_RESET 3'h0

`endif

// [dv/dscg_gate_bank_properties.sv]
// concurrent checks on the ports of the clock gate bank
`timescale 1ns/1ns
module dscg_gate_bank_checker
  import dscg_pkg::*;
#(
  parameter int ADDR_WIDTH = 12,
  parameter int UNITS = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_active,
  input wire logic deep_sleep_active,
  input wire logic [UNITS-1:0] unit_req_psel,
  input wire logic unit_req_penable,
  input wire logic [UNITS-1:0] unit_pready,
  input wire logic [UNITS-1:0] unit_psel,
  input wire logic [UNITS-1:0] unit_rsp_pready,
  input wire logic [UNITS-1:0] unit_rsp_pslverr,
  input wire logic [UNITS-1:0] unit_clk,
  input wire logic [UNITS-1:0] unit_clk_on,
  input wire logic [1:0] power_state,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic acc_d1, acc_d2;
  logic [1:0] ps_d1, ps_d2;
  // delayed write strobe and power state explain every enable change
  always_ff @(posedge clk) begin
    acc_d1 <= psel && penable && pwrite;
    acc_d2 <= acc_d1;
    ps_d1 <= power_state;
    ps_d2 <= ps_d1;
  end
  reset_values_a: assert property ($fell(srst) |-> prdata == 0 && !pslverr && unit_clk_on == 0 && !irq)
    else $error("outputs not at reset values");
  answer_ready_a: assert property (psel && !penable && pwrite |=> pready && prdata == 0)
    else $error("write not answered at once with zero data");
  map_ok_a: assert property (psel && !penable && paddr == 12'h120 |=> !pslverr)
    else $error("deep gate register answered with error");
  map_err_a: assert property (psel && !penable && paddr == 12'h200 |=> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  blocked_watchdog_a: assert property (unit_req_psel[0] && !unit_req_penable && !unit_clk_on[0]
    |-> (!unit_psel[0] && unit_rsp_pready[0] && unit_rsp_pslverr[0]) [*2])
    else $error("watchdog access not faulted");
  blocked_pwm_a: assert property (unit_req_psel[2] && !unit_req_penable && !unit_clk_on[2]
    |-> ##1 (unit_rsp_pslverr[2] && !unit_psel[2]))
    else $error("modulator access not faulted");
  pass_through_a: assert property (unit_req_psel[0] && !unit_req_penable && unit_clk_on[0]
    |-> unit_psel[0] && unit_rsp_pready[0] == unit_pready[0])
    else $error("clocked unit access not passed on");
  clock_follow_a: assert property (@(negedge clk) unit_clk == $past(unit_clk_on))
    else $error("gated clock does not follow its enable");
  deep_state_a: assert property (deep_sleep_active |=> power_state == 2'h3)
    else $error("deep sleep state not taken");
  sleep_state_a: assert property (sleep_active && !deep_sleep_active |=> power_state == 2'h1)
    else $error("sleep state not taken");
  enable_cause_a: assert property ($changed(unit_clk_on) |-> acc_d2 || ps_d1 != ps_d2)
    else $error("clock enable changed without cause");
endmodule

bind dscg_gate_bank dscg_gate_bank_checker #(.ADDR_WIDTH(ADDR_WIDTH), .UNITS(UNITS)) checker_inst (.clk, .srst,
  .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .sleep_active, .deep_sleep_active, .unit_req_psel,
  .unit_req_penable, .unit_pready, .unit_psel, .unit_rsp_pready, .unit_rsp_pslverr, .unit_clk, .unit_clk_on,
  .power_state, .irq);

// [dv/dscg_unit_model.sv]
// model of the three gated units answering on the unit bus
`timescale 1ns/1ns
module dscg_unit_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] unit_psel,
  input wire logic unit_req_penable,
  input wire logic [2:0] unit_clk_on,
  input wire logic [3:0] wait_cycles,
  output logic [2:0] unit_pready,
  output logic [2:0] unit_pslverr
);
  logic [3:0] cnt, next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (!(|unit_psel) || !unit_req_penable) begin
      next_cnt = 4'h0;
    end else if (cnt != wait_cycles) begin
      next_cnt = cnt + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    cnt <= srst ? 4'h0 : next_cnt;
  end
  // a unit answers only while it is clocked
  assign unit_pready = (unit_req_penable && cnt == wait_cycles) ? (unit_psel & unit_clk_on) : 3'h0;
  assign unit_pslverr = 3'h0;
endmodule

// [dv/tb.sv]
// self-checking bench for the clock gate bank
`timescale 1ns/1ns
module tb;
  import dscg_pkg::*;
  typedef struct {logic [11:0] a; dscg_word_t d; dscg_word_t q; logic e;} dscg_row_t;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, sleep_active = 0, deep_sleep_active = 0;
  logic unit_req_penable = 0, pready, pslverr, irq, err, seen_sel;
  logic [11:0] paddr = '0;
  dscg_word_t pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf, wait_cycles = 4'h0;
  logic [2:0] unit_req_psel = '0, unit_pready, unit_pslverr, unit_psel, unit_rsp_pready, unit_rsp_pslverr;
  logic [2:0] unit_clk, unit_clk_on;
  logic [1:0] power_state;
  int mismatches = 0, check_count = 0, n;
  int edges [3];
  dscg_row_t rows [7] = '{'{12'h120, 32'hffffffff, 32'h00110048, 1'b0}, '{12'h120, 32'h0, 32'h40, 1'b0},
    '{12'h120, 32'h00010000, 32'h00010040, 1'b0}, '{12'h120, 32'h8, 32'h48, 1'b0},
    '{12'h144, 32'h00110008, 32'h00110008, 1'b0}, '{12'h200, 32'h12345678, 32'h0, 1'b1},
    '{12'h120, 32'h00100000, 32'h00100040, 1'b0}};
  always #5 clk = ~clk;
  for (genvar g = 0; g < 3; g++) begin : edge_g
    always @(posedge unit_clk[g]) edges[g]++;
  end
  dscg_gate_bank dscg_gate_bank_inst (.clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .sleep_active, .deep_sleep_active, .unit_req_psel, .unit_req_penable, .unit_pready,
    .unit_pslverr, .unit_psel, .unit_rsp_pready, .unit_rsp_pslverr, .unit_clk, .unit_clk_on, .power_state, .irq);
  dscg_unit_model dscg_unit_model_inst (.clk, .srst, .unit_psel, .unit_req_penable, .unit_clk_on, .wait_cycles,
    .unit_pready, .unit_pslverr);
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string name, input dscg_word_t seen, input dscg_word_t exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input dscg_word_t d);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin mismatches++; tally_and_finish(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task uacc(input int i);
    @(posedge clk);
    unit_req_psel <= 3'(1 << i);
    @(posedge clk);
    unit_req_penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (unit_rsp_pready[i] !== 1'b1 && n < 20);
    if (unit_rsp_pready[i] !== 1'b1) begin mismatches++; tally_and_finish(); end
    err = unit_rsp_pslverr[i];
    seen_sel = unit_psel[i];
    unit_req_psel <= '0;
    unit_req_penable <= 1'b0;
    @(negedge clk);
  endtask
  task clocks(input logic [2:0] exp);
    @(negedge clk);
    edges = '{0, 0, 0};
    repeat (10) @(negedge clk);
    for (int g = 0; g < 3; g++) chk("unit clock edges", 32'(edges[g]), exp[g] ? 32'ha : 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      apb(12'h100 + 12'(k * 16), 1'b0, 32'h0);
      chk("gate reset value", rd, 32'h40);
    end
    chk("enables at reset", 32'(unit_clk_on), 32'h0);
    clocks(3'b000);
    $display("test reset done");
    foreach (rows[k]) begin
      apb(rows[k].a, 1'b1, rows[k].d);
      chk("write error", 32'(err), 32'(rows[k].e));
      apb(rows[k].a, 1'b0, 32'h0);
      chk("read back", rd, rows[k].q);
    end
    $display("test register table done");
    for (int k = 0; k < 3; k++) begin
      uacc(k);
      chk("fault on gated unit", 32'({err, seen_sel}), 32'h2);
    end
    chk("irq after fault", 32'(irq), 32'h1);
    apb(12'h140, 1'b0, 32'h0);
    chk("fault status", rd, 32'h00110008);
    apb(12'h148, 1'b1, 32'h00110008);
    @(negedge clk);
    chk("irq after clear", 32'(irq), 32'h0);
    apb(12'h144, 1'b1, 32'h0);
    uacc(2);
    chk("masked irq", 32'(irq), 32'h0);
    apb(12'h140, 1'b0, 32'h0);
    chk("masked status", rd, 32'h00100000);
    apb(12'h14c, 1'b0, 32'h0);
    chk("fault info", rd, 32'h00100000);
    $display("test fault done");
    apb(12'h100, 1'b1, 32'h8);
    repeat (2) @(negedge clk);
    chk("run enables", 32'(unit_clk_on), 32'h1);
    clocks(3'b001);
    for (int w = 0; w < 4; w += 3) begin
      @(posedge clk);
      wait_cycles <= 4'(w);
      uacc(0);
      chk("pass through", 32'({err, seen_sel, 4'(n)}), 32'({26'h1, 4'(w + 1)}));
    end
    $display("test run gating done");
    apb(12'h130, 1'b1, 32'h1);
    @(posedge clk);
    deep_sleep_active <= 1'b1;
    repeat (3) @(negedge clk);
    chk("deep enables", 32'(unit_clk_on), 32'h4);
    clocks(3'b100);
    apb(12'h130, 1'b0, 32'h0);
    chk("deep config", rd, 32'h31);
    apb(12'h130, 1'b1, 32'h0);
    repeat (2) @(negedge clk);
    chk("auto gating off", 32'(unit_clk_on), 32'h1);
    apb(12'h130, 1'b1, 32'h1);
    @(posedge clk);
    deep_sleep_active <= 1'b0;
    sleep_active <= 1'b1;
    repeat (3) @(negedge clk);
    chk("sleep enables", 32'(unit_clk_on), 32'h0);
    apb(12'h130, 1'b0, 32'h0);
    chk("sleep config", rd, 32'h11);
    $display("test power states done");
    @(posedge clk);
    srst <= 1'b1;
    sleep_active <= 1'b0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    apb(12'h120, 1'b0, 32'h0);
    chk("gate after reset", rd, 32'h40);
    chk("enables after reset", 32'(unit_clk_on), 32'h0);
    apb(12'h140, 1'b0, 32'h0);
    chk("status after reset", rd, 32'h0);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
